//--- tx_command_a_decoder.sv
// Decoder of command word A: offset skipping, padding removal and the buffer loaded flag
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "tx_cmd_regs.svh"
module tx_command_a_decoder
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hw_valid,
  input wire logic [15:0] hw_data,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic out_valid,
  output tx_cmd_pkg::out_word_t out_word,
  output logic irq
);
  import tx_cmd_pkg::*;

  logic word_valid;
  logic [31:0] word_data;
  dec_state_t state;
  cmd_a_t cmd;
  logic [10:0] word_cnt;
  logic [11:0] end_byte;
  logic [10:0] data_words;
  logic [10:0] total_words;
  logic [3:0] lane_en;
  logic buffer_done;
  logic [31:0] status;
  logic [31:0] mask;

  halfword_packer packer
  (
    .clock(clock),
    .rst(rst),
    .hw_valid(hw_valid),
    .hw_data(hw_data),
    .word_valid(word_valid),
    .word_data(word_data)
  );

  // ********************************
  // Buffer geometry
  // ********************************
  always_comb
  begin
    end_byte = {7'h00, cmd.offset} + {1'b0, cmd.size};
    data_words = end_byte[12-1:2] + {10'h000, |end_byte[1:0]};
    // Reserved code falls back to word alignment so the stream never locks up
    case (cmd.align)
      `ALIGN_16: total_words = (data_words + 11'h003) & 11'h7fc;
      `ALIGN_32: total_words = (data_words + 11'h007) & 11'h7f8;
      default: total_words = data_words;
    endcase
  end

  always_comb
  begin
    logic [12:0] pos;
    pos = 13'h0000;
    for (int k = 0; k < 4; k++)
    begin
      pos = {word_cnt, 2'b00} + 13'(k);
      lane_en[k] = (pos >= {8'h00, cmd.offset}) && (pos < {1'b0, end_byte});
    end
  end

  always_comb
  begin
    buffer_done = 1'b0;
    if (word_valid && state == ST_DATA && word_cnt == total_words - 11'h001)
      buffer_done = 1'b1;
    if (word_valid && state == ST_CMD_B && total_words == 11'h000)
      buffer_done = 1'b1;
  end

  // ********************************
  // Sequencer
  // ********************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= ST_CMD_A;
      cmd <= '0;
      word_cnt <= 11'h000;
    end
    else if (word_valid)
    begin
      case (state)
        ST_CMD_A:
        begin
          cmd.completion <= word_data[`CMDA_COMPLETION_BIT];
          cmd.align <= word_data[`CMDA_ALIGN_HI:`CMDA_ALIGN_LO];
          cmd.offset <= word_data[`CMDA_OFFSET_HI:`CMDA_OFFSET_LO];
          cmd.size <= word_data[`CMDA_SIZE_HI:`CMDA_SIZE_LO];
          state <= ST_CMD_B;
        end
        ST_CMD_B:
        begin
          // Command B is consumed here; payload starts with the next word
          word_cnt <= 11'h000;
          state <= (total_words == 11'h000) ? ST_CMD_A : ST_DATA;
        end
        ST_DATA:
        begin
          word_cnt <= word_cnt + 11'h001;
          if (buffer_done)
            state <= ST_CMD_A;
        end
        default: state <= ST_CMD_A;
      endcase
    end
  end

  // ********************************
  // Output stream
  // ********************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_word <= '0;
    end
    else
    begin
      // Leading skipped words and trailing padding yield no lane and are dropped
      out_valid <= word_valid && state == ST_DATA && word_cnt < data_words && (|lane_en);
      out_word.data <= word_data;
      out_word.byte_en <= lane_en;
      out_word.last <= word_cnt == data_words - 11'h001;
    end
  end

  // ********************************
  // Status, mask and interrupt
  // ********************************
  always_ff @(posedge clock)
  begin
    if (rst)
      status <= `STATUS_RESET;
    else
    begin
      // A new event beats a clearing read in the same cycle
      if (reg_rd && reg_addr == `STATUS_ADDR)
        status <= `STATUS_RESET;
      if (buffer_done && cmd.completion)
        status[`LOADED_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      mask <= `MASK_RESET;
    else if (reg_wr && reg_addr == `MASK_ADDR)
      mask <= {31'h0000_0000, reg_wdata[`LOADED_BIT]};
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `STATUS_ADDR: reg_rdata <= status;
        `MASK_ADDR: reg_rdata <= mask;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ********************************
  // Checks
  // ********************************
  AST_FLAG_SET: assert property (@(posedge clock) disable iff (rst)
    buffer_done && cmd.completion |=> status[`LOADED_BIT])
    else $error("buffer loaded flag not raised");

  AST_FLAG_QUIET: assert property (@(posedge clock) disable iff (rst)
    !status[`LOADED_BIT] && !(buffer_done && cmd.completion) |=> !status[`LOADED_BIT])
    else $error("buffer loaded flag raised without cause");

  AST_IRQ_ROUTE: assert property (@(posedge clock) disable iff (rst)
    status[`LOADED_BIT] && mask[`LOADED_BIT] ##1 status[`LOADED_BIT] |-> irq)
    else $error("masked-in flag did not reach interrupt");

  AST_PAD_DROP: assert property (@(posedge clock) disable iff (rst)
    word_valid && state == ST_DATA && word_cnt >= data_words |=> !out_valid)
    else $error("padding word passed on");

  AST_ALIGN_16: assert property (@(posedge clock) disable iff (rst)
    buffer_done && state == ST_DATA && cmd.align == `ALIGN_16 |-> word_cnt[1:0] == 2'h3)
    else $error("16-byte alignment wrong");

  AST_ALIGN_32: assert property (@(posedge clock) disable iff (rst)
    buffer_done && state == ST_DATA && cmd.align == `ALIGN_32 |-> word_cnt[2:0] == 3'h7)
    else $error("32-byte alignment wrong");

  AST_SKIP_WORDS: assert property (@(posedge clock) disable iff (rst)
    word_valid && state == ST_DATA && word_cnt < {8'h00, cmd.offset[4:2]} |=> !out_valid)
    else $error("skipped word passed on");

  AST_FIRST_LANE: assert property (@(posedge clock) disable iff (rst)
    word_valid && state == ST_DATA && cmd.size != 11'h000 && word_cnt == {8'h00, cmd.offset[4:2]}
    |=> out_valid && out_word.byte_en[$past(cmd.offset[1:0])]
        && (out_word.byte_en & ((4'h1 << $past(cmd.offset[1:0])) - 4'h1)) == 4'h0)
    else $error("first byte lane wrong");

  AST_PAYLOAD_START: assert property (@(posedge clock) disable iff (rst)
    word_valid && state == ST_CMD_B |=> word_cnt == 11'h000 && !out_valid)
    else $error("payload did not start at third word");

endmodule : tx_command_a_decoder

//--- tx_cmd_regs.svh
// Offsets, field positions, reset values and alignment codes for the command A decoder
`ifndef TX_CMD_REGS_SVH
`define TX_CMD_REGS_SVH

// ********************************
// Register map
// ********************************
`define STATUS_ADDR 4'h0
`define MASK_ADDR 4'h4
`define STATUS_RESET 32'h0000_0000
`define MASK_RESET 32'h0000_0000
`define LOADED_BIT 0

// ********************************
// Command word A fields
// ********************************
`define CMDA_COMPLETION_BIT 31
`define CMDA_ALIGN_HI 25
`define CMDA_ALIGN_LO 24
`define CMDA_OFFSET_HI 20
`define CMDA_OFFSET_LO 16
`define CMDA_SIZE_HI 10
`define CMDA_SIZE_LO 0

// ********************************
// Alignment codes
// ********************************
`define ALIGN_4 2'h0
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2
`define ALIGN_RSVD 2'h3

`endif

//--- tx_cmd_pkg.sv
// Types shared by the command A decoder
package tx_cmd_pkg;

  typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_DATA} dec_state_t;

  typedef struct packed {
    logic completion;
    logic [1:0] align;
    logic [4:0] offset;
    logic [10:0] size;
  } cmd_a_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] byte_en;
    logic last;
  } out_word_t;

endpackage : tx_cmd_pkg

//--- halfword_packer.sv
// Pairs 16-bit host writes into 32-bit words, low half first
`timescale 1ns/1ps
module halfword_packer
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hw_valid,
  input wire logic [15:0] hw_data,
  output logic word_valid,
  output logic [31:0] word_data
);

  logic high_phase;
  logic [15:0] low_half;

  // ********************************
  // Pairing
  // ********************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      high_phase <= 1'b0;
      low_half <= 16'h0000;
    end
    else if (hw_valid)
    begin
      high_phase <= ~high_phase;
      if (!high_phase)
        low_half <= hw_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      word_valid <= 1'b0;
      word_data <= 32'h0000_0000;
    end
    else
    begin
      word_valid <= hw_valid && high_phase;
      if (hw_valid && high_phase)
        word_data <= {hw_data, low_half};
    end
  end

endmodule : halfword_packer

//--- host_writer.sv
// Host model that writes transmit buffers to the decoder as halfword pairs
`timescale 1ns/1ps
module host_writer
(
  input wire logic clock,
  output logic hw_valid,
  output logic [15:0] hw_data
);
  initial
  begin
    hw_valid = 1'b0;
    hw_data = 16'h0000;
  end

  // ********************************
  // Word and buffer writes
  // ********************************
  // Low half first; strobe stays high so words go back to back
  task send_word(input logic [31:0] w);
    @(posedge clock);
    hw_valid <= 1'b1;
    hw_data <= w[15:0];
    @(posedge clock);
    hw_data <= w[31:16];
  endtask : send_word

  // Words counts payload plus the padding that the alignment asks for
  task send_buffer(input logic comp, input logic [1:0] align, input logic [4:0] off, input logic [10:0] size,
                   input int words);
    send_word({comp, 5'h00, align, 3'h0, off, 5'h00, size});
    send_word(32'h0000_0000);
    for (int i = 0; i < words; i++)
      send_word(32'hc0de_0000 + 32'(i));
    @(posedge clock);
    hw_valid <= 1'b0;
    // Idle data is scrambled so a stale value never looks valid
    hw_data <= ~hw_data;
  endtask : send_buffer
endmodule : host_writer

//--- tb_tx_command_a_decoder.sv
// Self-checking bench for the command A decoder
`timescale 1ns/1ps
module tb_tx_command_a_decoder;
  import tx_cmd_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hw_valid;
  logic [15:0] hw_data;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic out_valid;
  out_word_t out_word;
  logic irq;
  int err_total = 0;
  int checked = 0;
  out_word_t exp_q[$];
  out_word_t got_q[$];

  always #12.5 clock = ~clock;

  host_writer host (.clock(clock), .hw_valid(hw_valid), .hw_data(hw_data));
  tx_command_a_decoder dut (.clock(clock), .rst(rst), .hw_valid(hw_valid), .hw_data(hw_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_valid(out_valid), .out_word(out_word), .irq(irq));

  // ********************************
  // Helpers
  // ********************************
  // Bytes outside the valid lanes are don't-care, so they are masked off
  function automatic logic [31:0] lanes(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lanes

  always @(posedge clock)
    if (out_valid === 1'b1)
      got_q.push_back({out_word.data & lanes(out_word.byte_en), out_word.byte_en, out_word.last});

  task cmp(input string what, input logic [36:0] exp, input logic [36:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", 37'(exp), 37'(reg_rdata));
  endtask : reg_read

  // Expected words come from byte positions only; padding yields nothing
  task run_buf(input logic comp, input logic [1:0] align, input int off, input int size, input int words);
    out_word_t w;
    for (int i = 0; i < (off + size + 3) / 4; i++)
    begin
      for (int k = 0; k < 4; k++)
        w.byte_en[k] = (4 * i + k >= off) && (4 * i + k < off + size);
      w.data = (32'hc0de_0000 + 32'(i)) & lanes(w.byte_en);
      w.last = (off + size - 1 >= 4 * i) && (off + size - 1 < 4 * i + 4);
      if (w.byte_en != 4'h0)
        exp_q.push_back(w);
    end
    host.send_buffer(comp, align, 5'(off), 11'(size), words);
    repeat (6) @(posedge clock);
    #1 cmp("word count", 37'(exp_q.size()), 37'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0)
      cmp("out_word", exp_q.pop_front(), got_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask : run_buf

  task stop_test;
    $display("Mismatches %0d of %0d comparisons", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // ********************************
  // Tests
  // ********************************
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    reg_read(4'h0, 32'h0);
    reg_read(4'h4, 32'h0);
    reg_write(4'h4, 32'h1);
    reg_read(4'h4, 32'h1);
    reg_read(4'h8, 32'h0);
    run_buf(1'b1, 2'h1, 5, 6, 4);
    cmp("irq", 37'(1), 37'(irq));
    reg_read(4'h0, 32'h1);
    reg_read(4'h0, 32'h0);
    repeat (2) @(posedge clock);
    cmp("irq", 37'(0), 37'(irq));
    run_buf(1'b0, 2'h2, 0, 4, 8);
    reg_read(4'h0, 32'h0);
    run_buf(1'b1, 2'h0, 31, 1, 8);
    reg_read(4'h0, 32'h1);
    reg_write(4'h4, 32'h0);
    run_buf(1'b1, 2'h1, 3, 13, 4);
    cmp("irq", 37'(0), 37'(irq));
    reg_read(4'h0, 32'h1);
    run_buf(1'b1, 2'h1, 0, 0, 0);
    reg_read(4'h0, 32'h1);
    stop_test();
  end

  // Whole run is about 140 cycles; the 2000-cycle limit is ample margin
  initial
  begin
    #50000;
    err_total++;
    stop_test();
  end
endmodule : tb_tx_command_a_decoder
